// >>> amp_ctl_pkg.sv
package amp_ctl_pkg;

    // ========================================
    // register map, page zero
    localparam logic [7:0] ADDR_PAGE_SELECT    = 8'h00;
    localparam logic [7:0] ADDR_SOFT_RESET     = 8'h01;
    localparam logic [7:0] ADDR_POWER_MODE     = 8'h02;
    localparam logic [7:0] PAGE_ZERO           = 8'h00;

    // ========================================
    // reset values
    localparam logic [7:0] RST_PAGE_SELECT     = 8'h00;
    localparam logic [7:0] RST_SOFT_RESET      = 8'h00;
    localparam logic [7:0] RST_POWER_MODE      = 8'h0e;

    // ========================================
    // field positions
    localparam int         BIT_SOFT_RESET      = 0;
    localparam int         BIT_PDM_SERIAL      = 7;
    localparam int         BIT_LOAD_DIAG_ONLY  = 6;
    localparam int         BIT_RSVD_HI         = 5;
    localparam int         BIT_RSVD_LO         = 4;
    localparam int         BIT_ISENSE_PD       = 3;
    localparam int         BIT_VSENSE_PD       = 2;
    localparam int         BIT_MODE_HI         = 1;
    localparam int         BIT_MODE_LO         = 0;

    // ========================================
    // operating mode codes
    localparam logic [1:0] MODE_ACTIVE         = 2'h0;
    localparam logic [1:0] MODE_MUTE           = 2'h1;
    localparam logic [1:0] MODE_SHUTDOWN       = 2'h2;
    localparam logic [1:0] MODE_DIAG_THEN_ACT  = 2'h3;

    typedef enum logic [1:0]
    {
        OP_ACTIVE,
        OP_MUTE,
        OP_SHUTDOWN,
        OP_DIAG
    } op_state_t;

    // ========================================
    // register access request
    typedef struct packed
    {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // ========================================
    // power control fields
    typedef struct packed
    {
        logic       pulse_density_serial_enable;
        logic       load_diag_only_trigger;
        logic [1:0] rsvd;
        logic       current_sense_powerdown;
        logic       voltage_sense_powerdown;
        logic [1:0] mode;
    } power_mode_t;

endpackage

// >>> amp_op_seq.sv
module amp_op_seq
    import amp_ctl_pkg::*;
(
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   soft_clear,
    // control
    input  wire logic [1:0]             mode,
    input  wire logic                   diag_only_req,
    input  wire logic                   diag_done,
    // status
    output      amp_ctl_pkg::op_state_t state,
    output      logic                   diag_run,
    output      logic                   diag_only_done
);
    import amp_ctl_pkg::*;

    op_state_t next_state;
    logic      diag_only;

    // ========================================
    // operating mode sequencer
    always_comb
    begin
        next_state = state;
        case (state)
            OP_DIAG:
                if (diag_done && !diag_only)
                    next_state = OP_ACTIVE;
                else if (diag_done)
                    next_state = OP_SHUTDOWN;
            default:
                // trigger still reads set in the cycle its run ends
                if (diag_only_req && !diag_only_done)
                    next_state = OP_DIAG;
                else
                begin
                    case (mode)
                        MODE_ACTIVE:   next_state = OP_ACTIVE;
                        MODE_MUTE:     next_state = OP_MUTE;
                        MODE_SHUTDOWN: next_state = OP_SHUTDOWN;
                        default:
                            if (state != OP_ACTIVE)
                                next_state = OP_DIAG;
                    endcase
                end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            state <= OP_SHUTDOWN;
        else if (soft_clear)
            state <= OP_SHUTDOWN;
        else
            state <= next_state;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            diag_only <= 1'b0;
        else if (soft_clear)
            diag_only <= 1'b0;
        else if (state != OP_DIAG)
            diag_only <= diag_only_req;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            diag_run <= 1'b0;
        else if (soft_clear)
            diag_run <= 1'b0;
        else
            diag_run <= (next_state == OP_DIAG);
    end

    // one-cycle pulse ending a diagnostics-only run
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            diag_only_done <= 1'b0;
        else if (soft_clear)
            diag_only_done <= 1'b0;
        else
            diag_only_done <= (state == OP_DIAG) && diag_done && diag_only;
    end

endmodule

// >>> amp_page_reset_power_ctl.sv
module amp_page_reset_power_ctl
    import amp_ctl_pkg::*;
(
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // register port
    input  wire amp_ctl_pkg::reg_req_t  req,
    output      logic [7:0]             rdata,
    output      logic                   rvalid,
    // diagnostics engine
    input  wire logic                   diag_done,
    output      logic                   diag_run,
    // power and mode outputs
    output      logic [7:0]             page,
    output      logic                   pdm_serial_en,
    output      logic                   isense_pd,
    output      logic                   vsense_pd,
    output      logic                   amp_active,
    output      logic                   amp_mute,
    output      logic                   amp_shutdown,
    output      logic                   soft_reset_pulse
);
    import amp_ctl_pkg::*;

    power_mode_t pwr;
    logic        soft_clear;
    logic        in_page0;
    logic        wr_page;
    logic        wr_soft;
    logic        wr_pwr;
    logic        diag_only_done;
    op_state_t   state;
    logic [7:0]  next_rdata;

    // ========================================
    // address decode
    assign in_page0 = (page == PAGE_ZERO);
    assign wr_page  = req.wr && (req.addr == ADDR_PAGE_SELECT);
    assign wr_soft  = req.wr && in_page0 && (req.addr == ADDR_SOFT_RESET);
    assign wr_pwr   = req.wr && in_page0 && (req.addr == ADDR_POWER_MODE);

    // soft reset fires on a written one only
    assign soft_clear = wr_soft && req.wdata[BIT_SOFT_RESET];

    // ========================================
    // page select
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            page <= RST_PAGE_SELECT;
        else if (soft_clear)
            page <= RST_PAGE_SELECT;
        else if (wr_page)
            page <= req.wdata;
    end

    // ========================================
    // power control register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pwr <= RST_POWER_MODE;
        else if (soft_clear)
            pwr <= RST_POWER_MODE;
        else if (wr_pwr)
        begin
            pwr.pulse_density_serial_enable <= req.wdata[BIT_PDM_SERIAL];
            pwr.load_diag_only_trigger      <= req.wdata[BIT_LOAD_DIAG_ONLY]
                                            || (pwr.load_diag_only_trigger && !diag_only_done);
            pwr.rsvd                        <= RST_POWER_MODE[BIT_RSVD_HI:BIT_RSVD_LO];
            pwr.current_sense_powerdown     <= req.wdata[BIT_ISENSE_PD];
            pwr.voltage_sense_powerdown     <= req.wdata[BIT_VSENSE_PD];
            pwr.mode                        <= req.wdata[BIT_MODE_HI:BIT_MODE_LO];
        end
        else if (diag_only_done)
            pwr.load_diag_only_trigger <= 1'b0;
    end

    // ========================================
    // operating mode sequencer
    amp_op_seq u_seq
    (
        .clk            (clk),
        .rst_n          (rst_n),
        .soft_clear     (soft_clear),
        .mode           (pwr.mode),
        .diag_only_req  (pwr.load_diag_only_trigger),
        .diag_done      (diag_done),
        .state          (state),
        .diag_run       (diag_run),
        .diag_only_done (diag_only_done)
    );

    // ========================================
    // registered outputs
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pdm_serial_en <= RST_POWER_MODE[BIT_PDM_SERIAL];
            isense_pd     <= RST_POWER_MODE[BIT_ISENSE_PD];
            vsense_pd     <= RST_POWER_MODE[BIT_VSENSE_PD];
        end
        else
        begin
            pdm_serial_en <= pwr.pulse_density_serial_enable;
            isense_pd     <= pwr.current_sense_powerdown;
            vsense_pd     <= pwr.voltage_sense_powerdown;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            amp_active   <= 1'b0;
            amp_mute     <= 1'b0;
            amp_shutdown <= 1'b1;
        end
        else
        begin
            amp_active   <= (state == OP_ACTIVE);
            amp_mute     <= (state == OP_MUTE);
            amp_shutdown <= (state == OP_SHUTDOWN);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            soft_reset_pulse <= 1'b0;
        else
            soft_reset_pulse <= soft_clear;
    end

    // ========================================
    // read path
    always_comb
    begin
        next_rdata = 8'h00;
        if (req.addr == ADDR_PAGE_SELECT)
            next_rdata = page;
        else if (in_page0 && (req.addr == ADDR_SOFT_RESET))
            next_rdata = RST_SOFT_RESET;
        else if (in_page0 && (req.addr == ADDR_POWER_MODE))
            next_rdata = pwr;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata  <= 8'h00;
            rvalid <= 1'b0;
        end
        else
        begin
            rdata  <= req.rd ? next_rdata : 8'h00;
            rvalid <= req.rd;
        end
    end

endmodule

// >>> amp_page_reset_power_ctl_properties.sv
module amp_ctl_checker
    import amp_ctl_pkg::*;
(
    // clock and reset
    input wire logic                  clk,
    input wire logic                  rst_n,
    // watched ports
    input wire amp_ctl_pkg::reg_req_t req,
    input wire logic [7:0]            rdata,
    input wire logic                  rvalid,
    input wire logic                  diag_done,
    input wire logic                  diag_run,
    input wire logic [7:0]            page,
    input wire logic                  pdm_serial_en,
    input wire logic                  isense_pd,
    input wire logic                  vsense_pd,
    input wire logic                  amp_active,
    input wire logic                  amp_mute,
    input wire logic                  amp_shutdown,
    input wire logic                  soft_reset_pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ========================================
    // request sequences
    sequence s_pwr_wr;
        req.wr && req.addr == ADDR_POWER_MODE && page == PAGE_ZERO;
    endsequence
    sequence s_soft_wr;
        req.wr && req.addr == ADDR_SOFT_RESET && page == PAGE_ZERO && req.wdata[0];
    endsequence
    // ========================================
    // properties
    property p_read_ack; req.rd |=> rvalid; endproperty
    property p_page_wr; req.wr && req.addr == ADDR_PAGE_SELECT |=> page == $past(req.wdata);
    endproperty
    property p_soft_rd; req.rd && req.addr == ADDR_SOFT_RESET |=> rdata == 8'h00; endproperty
    property p_rsvd_rd; req.rd && req.addr == ADDR_POWER_MODE |=> rdata[5:4] == 2'h0; endproperty
    property p_soft_rst;
        s_soft_wr |=> soft_reset_pulse && page == RST_PAGE_SELECT
            ##1 isense_pd && vsense_pd && !pdm_serial_en;
    endproperty
    property p_sense;
        s_pwr_wr |-> ##2 isense_pd == $past(req.wdata[BIT_ISENSE_PD], 2)
            && vsense_pd == $past(req.wdata[BIT_VSENSE_PD], 2);
    endproperty
    property p_mute;
        s_pwr_wr ##0 (req.wdata[1:0] == MODE_MUTE && !req.wdata[BIT_LOAD_DIAG_ONLY] && !diag_run)
            |-> ##3 amp_mute;
    endproperty
    property p_onehot; $onehot0({amp_active, amp_mute, amp_shutdown}); endproperty
    property p_diag_end; diag_run && diag_done |-> ##[1:3] !diag_run; endproperty
    a_read_ack: assert property (p_read_ack) else $error("read not answered");
    a_page_wr: assert property (p_page_wr) else $error("page not written");
    a_soft_rd: assert property (p_soft_rd) else $error("soft reset reg nonzero");
    a_rsvd_rd: assert property (p_rsvd_rd) else $error("reserved bits nonzero");
    a_soft_rst: assert property (p_soft_rst) else $error("soft reset missed");
    a_sense: assert property (p_sense) else $error("sense powerdown wrong");
    a_mute: assert property (p_mute) else $error("mute not entered");
    a_onehot: assert property (p_onehot) else $error("op state not one-hot");
    a_diag_end: assert property (p_diag_end) else $error("diagnostics not ended");
endmodule

bind amp_page_reset_power_ctl amp_ctl_checker u_chk (.clk(clk), .rst_n(rst_n), .req(req),
    .rdata(rdata), .rvalid(rvalid), .diag_done(diag_done), .diag_run(diag_run), .page(page),
    .pdm_serial_en(pdm_serial_en), .isense_pd(isense_pd), .vsense_pd(vsense_pd),
    .amp_active(amp_active), .amp_mute(amp_mute), .amp_shutdown(amp_shutdown),
    .soft_reset_pulse(soft_reset_pulse));

// >>> amp_diag_engine.sv
module amp_diag_engine
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // run control
    input  wire logic       diag_run,
    input  wire logic [3:0] delay,
    output      logic       diag_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] count;
    // one done pulse after delay plus one cycles of run
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count     <= 4'h0;
            diag_done <= 1'b0;
        end
        else
        begin
            diag_done <= diag_run && !diag_done && count == delay;
            count     <= (diag_run && !diag_done && count != delay) ? count + 4'h1 : 4'h0;
        end
    end
endmodule

// >>> amp_page_reset_power_ctl_tb.sv
module amp_page_reset_power_ctl_tb
    import amp_ctl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, rvalid, diag_done, diag_run, pdm, isns, vsns, act, mute, sd, srp;
    logic [7:0] rdata, page;
    logic [3:0] delay;
    reg_req_t   req;
    int         miscompares = 0, n_tests = 0, cycles = 0;
    amp_page_reset_power_ctl DUT (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
        .rvalid(rvalid), .diag_done(diag_done), .diag_run(diag_run), .page(page),
        .pdm_serial_en(pdm), .isense_pd(isns), .vsense_pd(vsns), .amp_active(act),
        .amp_mute(mute), .amp_shutdown(sd), .soft_reset_pulse(srp));
    amp_diag_engine u_diag (.clk(clk), .rst_n(rst_n), .diag_run(diag_run), .delay(delay),
        .diag_done(diag_done));
    always #2.5 clk = ~clk;
    // ========================================
    // tasks
    task summarize;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req = '{1'b1, 1'b0, a, d};
        @(negedge clk);
        req.wr = 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        req = '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk);
        req.rd = 1'b0;
        check({7'h0, rvalid}, 8'h01);
        check(rdata, exp);
    endtask
    task idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task wait_diag;
        for (int i = 0; i < 40 && diag_run === 1'b1; i++) @(negedge clk);
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            miscompares++;
            summarize();
        end
    end
    // ========================================
    // main sequence
    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        req = '0;
        delay = 4'h3;
        idle(10);
        rst_n = 1'b1;
        check({5'h0, isns, vsns, pdm}, 8'h06);
        check({5'h0, act, mute, sd}, 8'h01);
        rd(ADDR_PAGE_SELECT, RST_PAGE_SELECT);
        rd(ADDR_SOFT_RESET, RST_SOFT_RESET);
        rd(ADDR_POWER_MODE, RST_POWER_MODE);
        rd(8'h03, 8'h00);
        for (int m = 0; m < 3; m++)
        begin
            wr(ADDR_POWER_MODE, 8'hb4 | 8'(m));
            rd(ADDR_POWER_MODE, 8'h84 | 8'(m));
            idle(2);
            check({5'h0, act, mute, sd}, 8'h04 >> m);
            check({5'h0, pdm, isns, vsns}, 8'h05);
        end
        wr(ADDR_POWER_MODE, 8'h8f);
        idle(3);
        check({4'h0, diag_run, act, mute, sd}, 8'h08);
        wait_diag();
        idle(2);
        check({4'h0, diag_run, act, mute, sd}, 8'h04);
        delay = 4'h9;
        wr(ADDR_POWER_MODE, 8'h40);
        idle(3);
        check({7'h0, diag_run}, 8'h01);
        wait_diag();
        idle(3);
        check({4'h0, diag_run, act, mute, sd}, 8'h04);
        rd(ADDR_POWER_MODE, 8'h00);
        wr(ADDR_PAGE_SELECT, 8'hff);
        rd(ADDR_PAGE_SELECT, 8'hff);
        rd(ADDR_POWER_MODE, 8'h00);
        wr(ADDR_SOFT_RESET, 8'h01);
        wr(ADDR_PAGE_SELECT, PAGE_ZERO);
        rd(ADDR_POWER_MODE, 8'h00);
        wr(ADDR_POWER_MODE, 8'h85);
        wr(ADDR_SOFT_RESET, 8'h00);
        rd(ADDR_POWER_MODE, 8'h85);
        idle(2);
        wr(ADDR_SOFT_RESET, 8'h01);
        check({7'h0, srp}, 8'h01);
        rd(ADDR_SOFT_RESET, 8'h00);
        rd(ADDR_POWER_MODE, RST_POWER_MODE);
        wr(ADDR_PAGE_SELECT, 8'h33);
        rst_n = 1'b0;
        idle(1);
        check(page, RST_PAGE_SELECT);
        rst_n = 1'b1;
        idle(2);
        summarize();
    end
endmodule
